/* File: pkg/ssb_pkg.sv */
// Package for the SPI-mode shift buffer: register map, field positions, types.
package ssb_pkg;

  // Register byte offsets (word aligned)
  localparam logic [3:0] SSB_OFF_STATUS = 4'h0;
  localparam logic [3:0] SSB_OFF_CTRL1 = 4'h4;
  localparam logic [3:0] SSB_OFF_CTRL3 = 4'h8;
  localparam logic [3:0] SSB_OFF_DATA = 4'hc;
  localparam logic [4:0] SSB_OFF_RELOAD = 5'h10;
  localparam logic [4:0] SSB_OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] SSB_OFF_IRQ_MASK = 5'h18;
  localparam int SSB_ADDR_W = 5;

  // Status register fields
  localparam int SSB_ST_SMP = 7;
  localparam int SSB_ST_CKE = 6;
  localparam int SSB_ST_BF = 0;

  // Control one fields
  localparam int SSB_C1_WRITE_COLLISION_FLAG = 7;
  localparam int SSB_C1_EN = 5;
  localparam int SSB_C1_CKP = 4;

  // Control one mode encodings in bits 3:0
  localparam logic [3:0] SSB_MODE_M_DIV4 = 4'h0;
  localparam logic [3:0] SSB_MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] SSB_MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] SSB_MODE_M_RELOAD = 4'ha;
  localparam logic [3:0] SSB_MODE_S_SEL = 4'h4;
  localparam logic [3:0] SSB_MODE_S_NOSEL = 4'h5;

  // Interrupt bits
  localparam int SSB_IRQ_BYTE = 0;
  localparam int SSB_IRQ_WRITE_COLLISION_FLAG = 1;

  // Reset values
  localparam logic [7:0] SSB_RST_BYTE = 8'h00;

  // Byte width of the shift path
  localparam int SSB_BITS = 8;
  localparam logic [2:0] SSB_LAST_BIT = 3'h7;
  // Last of the sixteen link clock half periods of one byte
  localparam logic [3:0] SSB_LAST_HALF = 4'hf;

  // Avalon-MM request bundle
  typedef struct packed {
    logic [SSB_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ssb_av_req_t;

  // Serial pin bundle toward the link
  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic sdo_o;
    logic sdo_oe_n;
  } ssb_pins_t;

  typedef enum logic [1:0] {
    SSB_IDLE = 2'b00,
    SSB_SHIFT = 2'b01,
    SSB_DONE = 2'b10
  } ssb_state_t;

endpackage

/* File: verilog/ssb_core.sv */
// SPI-mode synchronous serial port core with Avalon-MM register access.
`timescale 1ns/1ps

// Functional notes
// RULE_01: Eight-bit shift register, most significant bit sent first.
// RULE_02: Incoming bit enters at the least significant position as top bit leaves.
// RULE_03: Output changes on the active clock edge, input sampled on the other.
// RULE_04: Master starts transfers by driving the clock; both share idle polarity.
// RULE_05: After eight bits the two shift registers have swapped contents.
// RULE_06: Master clocks only whole bytes, then stops clock and deselects.
// RULE_07: Master selects one slave at a time, one select per slave.
// RULE_08: Unselected slave ignores clock and data and leaves its output undriven.
// RULE_09: Complete byte is copied into data buffer and sets interrupt flag.
// RULE_10: Buffer write loads both data buffer and shift register.
// RULE_11: Shift register reachable only through the data buffer.
// RULE_12: Status low six bits read-only, top two bits read/write.
// RULE_13: Control one fully read/write in this mode.
// RULE_14: One master rate mode takes its reload from the reload register.
// RULE_15: Reload rate gives serial clock of clock over four times reload plus one. The code keeps this only for reload up to 127.
// RULE_16: In master mode a buffer write starts the transfer at once.
// RULE_17: Write during transfer is dropped, sets collision flag, blocks writes until cleared.
// RULE_18: Received byte sets buffer-full; reading the buffer clears it.
// RULE_19: External clock and select pass a two-stage synchroniser first.
module ssb_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire ssb_pkg::ssb_av_req_t av_req_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  // Serial link
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic ss_n_i,
  output ssb_pkg::ssb_pins_t pins_o,
  output logic ss_n_o,
  // Interrupt
  output logic irq_o
);
  import ssb_pkg::*;

  logic [7:0] status_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl3_q;
  logic [7:0] buf_q;
  logic [7:0] reload_q;
  logic [7:0] shift_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] rate_cnt_q;
  logic phase_q;
  logic sample_q;
  ssb_state_t state_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic wait_q;
  logic sck_q;
  // Captured input bit held between sample and shift edges
  logic in_bit_q;
  // A sample is waiting for its shift edge
  logic pend_q;
  logic [3:0] half_cnt_q;
  logic sck_oe_n_q;
  logic sdo_q;
  logic sdo_oe_n_q;
  logic ss_out_q;
  logic irq_q;
  logic [1:0] sck_sync_q;
  logic [1:0] ss_sync_q;
  logic sck_prev_q;

  // Decoded mode bits, access strobes, rate tick and link edges
  logic enable;
  logic ckp;
  logic cke;
  logic is_master;
  logic is_slave_sel;
  logic selected;
  logic wr_acc;
  logic rd_acc;
  logic busy;
  logic buf_wr;
  logic buf_wr_ok;
  logic buf_rd;
  logic byte_done;
  logic tick;
  logic [7:0] rate_top;
  logic s_lead;
  logic s_trail;
  logic s_rise;
  logic s_fall;

  // Word offset match used by several decoders
  function automatic logic hit(input logic [SSB_ADDR_W-1:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  assign enable = ctrl1_q[SSB_C1_EN];
  assign ckp = ctrl1_q[SSB_C1_CKP];
  assign cke = status_q[SSB_ST_CKE];
  assign is_master = (ctrl1_q[3:0] == SSB_MODE_M_DIV4) || (ctrl1_q[3:0] == SSB_MODE_M_DIV16) ||
                     (ctrl1_q[3:0] == SSB_MODE_M_DIV64) || (ctrl1_q[3:0] == SSB_MODE_M_RELOAD);
  assign is_slave_sel = (ctrl1_q[3:0] == SSB_MODE_S_SEL);
  // Without select control the slave counts itself always selected
  assign selected = !is_slave_sel || !ss_sync_q[1]; // RULE_08
  // One-cycle answer: waitrequest is low in the cycle after the request appears
  assign wr_acc = av_req_i.write && ack_q;
  assign rd_acc = av_req_i.read && ack_q;
  assign busy = (state_q != SSB_IDLE);
  assign buf_wr = wr_acc && hit(av_req_i.address, {1'b0, SSB_OFF_DATA});
  // Collision flag still set also blocks the write
  assign buf_wr_ok = buf_wr && !busy && !ctrl1_q[SSB_C1_WRITE_COLLISION_FLAG]; // RULE_17
  assign buf_rd = rd_acc && hit(av_req_i.address, {1'b0, SSB_OFF_DATA});

  // Master half-period: divide by 4 gives 2 cycles per half
  always_comb begin
    unique case (ctrl1_q[3:0])
      SSB_MODE_M_DIV16: rate_top = 8'h07;
      SSB_MODE_M_DIV64: rate_top = 8'h1f;
      // For reload up to 127: period 4*(reload+1) cycles, half period 2*(reload+1)
      SSB_MODE_M_RELOAD: rate_top = 8'((({1'b0, reload_q} + 9'h001) << 1) - 9'h001); // RULE_14 RULE_15
      default: rate_top = 8'h01;
    endcase
  end
  assign tick = (rate_cnt_q == rate_top);

  // Slave edges seen only on the synchronised clock
  assign s_rise = sck_sync_q[1] && !sck_prev_q;
  assign s_fall = !sck_sync_q[1] && sck_prev_q;
  // Leading edge leaves idle; with cke set data changes on that edge
  assign s_lead = ckp ? s_fall : s_rise;
  assign s_trail = ckp ? s_rise : s_fall;
  // Not gated by busy: in master mode with cke clear the last sample lands on the final edge
  assign byte_done = (bit_cnt_q == SSB_LAST_BIT) && sample_q;

  // Two-stage synchronisers for slave clock and select
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sck_sync_q <= 2'b00;
      ss_sync_q <= 2'b11;
      sck_prev_q <= 1'b0;
    end else begin
      sck_sync_q <= {sck_sync_q[0], sck_i}; // RULE_19
      ss_sync_q <= {ss_sync_q[0], ss_n_i}; // RULE_19
      sck_prev_q <= sck_sync_q[1];
    end
  end

  // Bus handshake: one wait cycle per access
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      ack_q <= (av_req_i.read || av_req_i.write) && !ack_q;
      // Registered copy so the bus output comes straight from a flop
      wait_q <= !((av_req_i.read || av_req_i.write) && !ack_q);
    end
  end

  // Read data mux, registered with the acknowledge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (av_req_i.read && !ack_q) begin
      unique case (av_req_i.address)
        {1'b0, SSB_OFF_STATUS}: rdata_q <= {24'h00_0000, status_q};
        {1'b0, SSB_OFF_CTRL1}: rdata_q <= {24'h00_0000, ctrl1_q};
        {1'b0, SSB_OFF_CTRL3}: rdata_q <= {24'h00_0000, ctrl3_q};
        {1'b0, SSB_OFF_DATA}: rdata_q <= {24'h00_0000, buf_q}; // RULE_11
        SSB_OFF_RELOAD: rdata_q <= {24'h00_0000, reload_q};
        SSB_OFF_IRQ_STAT: rdata_q <= {30'h0000_0000, irq_stat_q};
        SSB_OFF_IRQ_MASK: rdata_q <= {30'h0000_0000, irq_mask_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Status: top two bits writable, buffer-full driven by hardware
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_q <= SSB_RST_BYTE;
    end else begin
      if (wr_acc && hit(av_req_i.address, {1'b0, SSB_OFF_STATUS})) begin
        status_q[7:6] <= av_req_i.writedata[7:6]; // RULE_12
      end
      // Load beats the read-clear when both land together
      if (byte_done) begin
        status_q[SSB_ST_BF] <= 1'b1; // RULE_18
      end else if (buf_rd) begin
        status_q[SSB_ST_BF] <= 1'b0; // RULE_18
      end
    end
  end

  // Control one, control three and reload registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl1_q <= SSB_RST_BYTE;
      ctrl3_q <= SSB_RST_BYTE;
      reload_q <= SSB_RST_BYTE;
    end else begin
      if (wr_acc && hit(av_req_i.address, {1'b0, SSB_OFF_CTRL1})) begin
        ctrl1_q <= av_req_i.writedata[7:0]; // RULE_13
      end
      // A fresh collision wins over the software clear
      if (buf_wr && (busy || ctrl1_q[SSB_C1_WRITE_COLLISION_FLAG])) begin
        ctrl1_q[SSB_C1_WRITE_COLLISION_FLAG] <= 1'b1; // RULE_17
      end
      if (wr_acc && hit(av_req_i.address, {1'b0, SSB_OFF_CTRL3})) begin
        ctrl3_q <= av_req_i.writedata[7:0];
      end
      if (wr_acc && hit(av_req_i.address, SSB_OFF_RELOAD)) begin
        reload_q <= av_req_i.writedata[7:0]; // RULE_14
      end
    end
  end

  // Data buffer: written by software, reloaded with each received byte
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      buf_q <= SSB_RST_BYTE;
    end else if (buf_wr_ok) begin
      buf_q <= av_req_i.writedata[7:0]; // RULE_10
    end else if (byte_done) begin
      buf_q <= {shift_q[6:0], in_bit_q}; // RULE_09
    end
  end

  // Transfer engine: master timing or slave edges drive sample and shift
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !enable) begin
      state_q <= SSB_IDLE;
      shift_q <= SSB_RST_BYTE;
      bit_cnt_q <= 3'h0;
      rate_cnt_q <= 8'h00;
      phase_q <= 1'b0;
      sample_q <= 1'b0;
      in_bit_q <= 1'b0;
      sck_q <= 1'b0;
      pend_q <= 1'b0;
      half_cnt_q <= 4'h0;
    end else begin
      sample_q <= 1'b0;
      if (buf_wr_ok) begin
        shift_q <= av_req_i.writedata[7:0]; // RULE_10 RULE_11
        bit_cnt_q <= 3'h0;
        rate_cnt_q <= 8'h00;
        phase_q <= 1'b0;
        pend_q <= 1'b0;
        half_cnt_q <= 4'h0;
        // Master starts at once; slave waits for the far master
        state_q <= is_master ? SSB_SHIFT : SSB_IDLE; // RULE_16 RULE_04
      end else if (is_master && state_q == SSB_SHIFT) begin
        rate_cnt_q <= tick ? 8'h00 : 8'(rate_cnt_q + 8'h01);
        if (tick) begin
          phase_q <= !phase_q;
          sck_q <= !sck_q;
          half_cnt_q <= 4'(half_cnt_q + 4'h1);
          // Leading edge samples when cke set, trailing edge otherwise
          if (phase_q ^ cke) begin
            in_bit_q <= sdi_i; // RULE_03
            sample_q <= 1'b1;
            pend_q <= 1'b1;
          end else if (pend_q) begin
            // Shift only after a sample so the top bit is never lost early
            shift_q <= {shift_q[6:0], in_bit_q}; // RULE_02
            bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
            pend_q <= 1'b0;
          end
          // Clock stops after the eighth full period
          if (half_cnt_q == SSB_LAST_HALF) begin
            state_q <= SSB_IDLE; // RULE_06
          end
        end
      end else if (!is_master && selected) begin
        if ((cke ? s_trail : s_lead) && !busy) begin
          state_q <= SSB_SHIFT;
        end
        if (cke ? s_trail : s_lead) begin
          in_bit_q <= sdi_i; // RULE_03
          sample_q <= 1'b1;
        end
        if ((cke ? s_lead : s_trail) && busy) begin
          shift_q <= {shift_q[6:0], in_bit_q}; // RULE_02
          bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
        end
      end else if (!is_master && is_slave_sel) begin
        // Deselect resets a half-received byte
        state_q <= SSB_IDLE;
        bit_cnt_q <= 3'h0;
      end
      if (!is_master) begin
        sck_q <= ckp;
      end else if (state_q == SSB_IDLE) begin
        sck_q <= ckp; // RULE_04
      end
      // Eighth sample completes the byte; shift registers now swapped
      if (byte_done) begin
        shift_q <= {shift_q[6:0], in_bit_q}; // RULE_05
        bit_cnt_q <= 3'h0;
        pend_q <= 1'b0;
        // With cke set the master still owes its last half period, so only a slave stops here
        if (!is_master) begin
          state_q <= SSB_IDLE;
        end
      end
    end
  end

  // Serial outputs, always from the top bit of the shift register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
      sck_oe_n_q <= 1'b1;
      ss_out_q <= 1'b1;
    end else begin
      sdo_q <= shift_q[SSB_BITS-1]; // RULE_01
      sdo_oe_n_q <= !(enable && (is_master || selected)); // RULE_08
      sck_oe_n_q <= !(enable && is_master);
      ss_out_q <= !(enable && is_master && busy); // RULE_06
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= 2'b00;
      irq_mask_q <= 2'b00;
      irq_q <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_acc && hit(av_req_i.address, SSB_OFF_IRQ_STAT) && av_req_i.writedata[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
      if (byte_done) begin
        irq_stat_q[SSB_IRQ_BYTE] <= 1'b1; // RULE_09
      end
      if (buf_wr && !buf_wr_ok) begin
        irq_stat_q[SSB_IRQ_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (wr_acc && hit(av_req_i.address, SSB_OFF_IRQ_MASK)) begin
        irq_mask_q <= av_req_i.writedata[1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign av_readdata_o = rdata_q;
  assign av_waitrequest_o = wait_q;
  assign pins_o = '{sck_o: sck_q, sck_oe_n: sck_oe_n_q, sdo_o: sdo_q, sdo_oe_n: sdo_oe_n_q};
  assign ss_n_o = ss_out_q;
  assign irq_o = irq_q;

endmodule

/* File: verif/ssb_core_sva.sv */
// Assertion checker for the SPI shift buffer core ports.
`timescale 1ns/1ps
module ssb_core_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register bus
  input wire ssb_pkg::ssb_av_req_t av_req_i,
  input wire logic [31:0] av_readdata_o,
  input wire logic av_waitrequest_o,
  // Link and interrupt
  input wire ssb_pkg::ssb_pins_t pins_o,
  input wire logic ss_n_o,
  input wire logic irq_o
);
  import ssb_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic req;
  logic dwr;
  logic sck_q;
  logic [3:0] edge_q;
  logic [7:0] tx_q;
  assign req = av_req_i.read | av_req_i.write;
  assign dwr = av_req_i.write && !av_waitrequest_o && av_req_i.address == {1'b0, SSB_OFF_DATA};
  // Rising link edges per frame; reset while deselected so each frame counts alone
  always_ff @(posedge clk_i) begin
    sck_q <= pins_o.sck_o;
    if (sys_rst_i || ss_n_o) edge_q <= 4'h0;
    else if (pins_o.sck_o && !sck_q) edge_q <= edge_q + 4'h1;
  end
  // Byte accepted for sending while the link is idle
  always_ff @(posedge clk_i) begin
    if (dwr && ss_n_o) tx_q <= av_req_i.writedata[7:0];
  end
  property p_wait_one; !av_waitrequest_o |=> av_waitrequest_o; endproperty
  property p_ack; req && av_waitrequest_o |=> !av_waitrequest_o; endproperty
  property p_no_spur; !av_waitrequest_o |-> $past(req); endproperty
  property p_upper0; !av_waitrequest_o |-> av_readdata_o[31:8] == 24'h0; endproperty
  property p_whole; $rose(ss_n_o) |-> edge_q == 4'h8; endproperty
  property p_start; dwr && ss_n_o |-> ##[1:4] !ss_n_o; endproperty
  property p_msb; $fell(ss_n_o) |-> ##[0:3] pins_o.sdo_o == tx_q[7]; endproperty
  property p_irq_fall; $fell(irq_o) |-> $past(av_req_i.write) || $past(av_req_i.write, 2); endproperty
  property p_sck_frame; $changed(pins_o.sck_o) |-> !ss_n_o || !$past(ss_n_o); endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low longer than one cycle");
  a_ack: assert property (p_ack) else $error("request not answered after one wait cycle");
  a_no_spur: assert property (p_no_spur) else $error("answer without a request");
  a_upper0: assert property (p_upper0) else $error("upper read data bits not zero");
  a_whole: assert property (p_whole) else $error("frame not eight clock pulses");
  a_start: assert property (p_start) else $error("buffer write did not start a transfer");
  a_msb: assert property (p_msb) else $error("first bit out is not the top bit");
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without a write");
  a_sck_frame: assert property (p_sck_frame) else $error("link clock moved outside a frame");
  c_frame: cover property ($rose(ss_n_o));
  c_collide: cover property (dwr && !ss_n_o);
  c_irq: cover property ($rose(irq_o));
endmodule

/* File: verif/ssb_spi_peer.sv */
// Behavioural SPI slave that faces the core's master link.
`timescale 1ns/1ps
module ssb_spi_peer (
  // Link from the master
  input wire logic sck_i,
  input wire logic sdo_i,
  input wire logic ss_n_i,
  // Byte to send and byte received
  input wire logic [7:0] tx_i,
  output logic sdi_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh_q = 8'h00;
  initial sdi_o = 1'b0;
  initial rx_o = 8'h00;
  // Load on select so the top bit is on the line before the first edge
  always @(negedge ss_n_i) begin
    sh_q = tx_i;
    sdi_o = sh_q[7];
  end
  // Sample on the rising edge, new bit enters at the bottom
  always @(posedge sck_i) if (!ss_n_i) sh_q = {sh_q[6:0], sdo_i};
  // Change output on the falling edge
  always @(negedge sck_i) if (!ss_n_i) sdi_o = sh_q[7];
  // Released line shows the inverse of the last bit, never a stale copy
  always @(posedge ss_n_i) begin
    rx_o = sh_q;
    sdi_o = ~sdi_o;
  end
endmodule

/* File: verif/ssb_core_tb.sv */
// Self-checking bench for the SPI shift buffer core in master mode.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module ssb_core_tb;
  import ssb_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  ssb_av_req_t av_req_i = '0;
  logic [31:0] av_readdata_o;
  logic av_waitrequest_o;
  logic sdi_i;
  logic ss_n_o;
  logic irq_o;
  ssb_pins_t pins_o;
  logic [7:0] peer_tx = 8'h00;
  logic [7:0] peer_rx;
  logic [31:0] rd;
  logic [3:0] modes [4] = '{SSB_MODE_M_DIV4, SSB_MODE_M_DIV16, SSB_MODE_M_DIV64, SSB_MODE_M_RELOAD};
  int halves [3] = '{2, 8, 32};
  int error_cnt = 0;
  int n_tests = 0;
  int hi_cnt = 0;
  int r = 0;
  int seed = int'(32'hbd158e87);
  int exp_q [$];
  always #4 clk_i = ~clk_i;
  // High time of the link clock inside frames, sampled away from the active edge
  always @(negedge clk_i) if (!ss_n_o && pins_o.sck_o) hi_cnt++;
  ssb_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .av_req_i(av_req_i), .av_readdata_o(av_readdata_o),
    .av_waitrequest_o(av_waitrequest_o), .sck_i(1'b0), .sdi_i(sdi_i), .ss_n_i(1'b1), .pins_o(pins_o),
    .ss_n_o(ss_n_o), .irq_o(irq_o));
  // Single slave on its own select line
  ssb_spi_peer peer (.sck_i(pins_o.sck_o), .sdo_i(pins_o.sdo_o), .ss_n_i(ss_n_o), .tx_i(peer_tx),
    .sdi_o(sdi_i), .rx_o(peer_rx));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_req_i <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (av_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) error_cnt++;
    rd = av_readdata_o;
    av_req_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask
  // Bounded wait for the select line to reach a level
  task automatic wait_ss(input logic lvl, input int lim);
    int n;
    n = 0;
    while (ss_n_o !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) error_cnt++;
  endtask
  // One byte exchange; optional second write during the frame and masked interrupt
  task automatic xfer(input logic [3:0] mode, input int half, input logic msk, input logic col);
    logic [7:0] tx;
    logic [7:0] pt;
    tx = 8'($random(seed));
    pt = 8'($random(seed));
    peer_tx <= pt;
    exp_q.push_back(pt);
    bus(1'b1, SSB_OFF_IRQ_MASK, {31'h0, msk});
    bus(1'b1, {1'b0, SSB_OFF_CTRL1}, {24'h0, 4'h2, mode});
    hi_cnt = 0;
    bus(1'b1, {1'b0, SSB_OFF_DATA}, {24'h0, tx});
    if (col) begin
      bus(1'b1, {1'b0, SSB_OFF_DATA}, 32'h5a);
      rd_chk({1'b0, SSB_OFF_CTRL1}, {24'h0, 4'ha, mode});
    end
    wait_ss(1'b0, 8);
    wait_ss(1'b1, 3000);
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, msk)
    `CHK(peer_rx, tx)
    `CHK(hi_cnt, 8 * half)
    rd_chk({1'b0, SSB_OFF_STATUS}, 32'h41);
    rd_chk({1'b0, SSB_OFF_DATA}, 32'(exp_q.pop_front()));
    rd_chk({1'b0, SSB_OFF_STATUS}, 32'h40);
    rd_chk(SSB_OFF_IRQ_STAT, col ? 32'h3 : 32'h1);
    bus(1'b1, SSB_OFF_IRQ_STAT, 32'h3);
    if (col) bus(1'b1, {1'b0, SSB_OFF_CTRL1}, {24'h0, 4'h2, mode});
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk({1'b0, SSB_OFF_STATUS}, 32'h0);
    rd_chk({1'b0, SSB_OFF_CTRL1}, 32'h0);
    rd_chk(5'h1c, 32'h0);
    bus(1'b1, {1'b0, SSB_OFF_CTRL1}, 32'h0f);
    rd_chk({1'b0, SSB_OFF_CTRL1}, 32'h0f);
    bus(1'b1, {1'b0, SSB_OFF_STATUS}, 32'hff);
    rd_chk({1'b0, SSB_OFF_STATUS}, 32'hc0);
    bus(1'b1, {1'b0, SSB_OFF_STATUS}, 32'h40);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed) & 7;
      bus(1'b1, SSB_OFF_RELOAD, 32'(r));
      xfer(modes[i % 4], (i % 4 == 3) ? 2 * (r + 1) : halves[i % 4], i != 2, i == 1);
      $display("test transfer %0d done", i);
    end
    report_and_stop;
  end
  // Watchdog well beyond the slowest sequence of transfers
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    report_and_stop;
  end
endmodule
bind ssb_core ssb_core_sva u_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .av_req_i(av_req_i),
  .av_readdata_o(av_readdata_o), .av_waitrequest_o(av_waitrequest_o), .pins_o(pins_o), .ss_n_o(ss_n_o),
  .irq_o(irq_o));
